/* File: hdl/enc_bridge_pkg.sv */
// Purpose: Shared constants of the encoder host bus bridge.
// Assumes: 32-bit multiplexed address/data bus clocked by REF_CLK.
// Notes:   Local buffer registers live in the upper index range.
package enc_bridge_pkg;
    localparam logic [3:0]  CMD_IO_RD     = 4'h2;
    localparam logic [3:0]  CMD_IO_WR     = 4'h3;
    localparam logic [3:0]  CMD_MEM_RD    = 4'h6;
    localparam logic [3:0]  CMD_MEM_WR    = 4'h7;
    localparam logic [3:0]  CMD_CFG_RD    = 4'ha;
    localparam logic [3:0]  CMD_CFG_WR    = 4'hb;
    localparam logic [3:0]  CMD_MEM_RDM   = 4'hc;
    localparam logic [3:0]  CMD_MEM_RDL   = 4'he;
    localparam logic [5:0]  CFG_ID        = 6'h00;
    localparam logic [5:0]  CFG_CMDSTAT   = 6'h01;
    localparam logic [5:0]  CFG_CLASS     = 6'h02;
    localparam logic [5:0]  CFG_BAR0      = 6'h04;
    localparam logic [5:0]  CFG_BAR1      = 6'h05;
    localparam logic [5:0]  CFG_BAR2      = 6'h06;
    localparam logic [5:0]  CFG_INTR      = 6'h0f;
    localparam logic [3:0]  IO_INDEX_OFS  = 4'h0;
    localparam logic [3:0]  IO_DATA_OFS   = 4'h4;
    localparam logic [3:0]  IO_STREAM_OFS = 4'h8;
    localparam logic [6:0]  IDX_SOUND     = 7'h67;
    localparam logic [6:0]  IDX_BUF0_BASE = 7'h70;
    localparam logic [6:0]  IDX_BUF1_BASE = 7'h71;
    localparam logic [6:0]  IDX_BUF0_SIZE = 7'h72;
    localparam logic [6:0]  IDX_BUF1_SIZE = 7'h73;
    localparam logic [6:0]  IDX_BUF_STATE = 7'h74;
    localparam int          BST_RDY0      = 0;
    localparam int          BST_RDY1      = 1;
    localparam int          BST_FULL0     = 2;
    localparam int          BST_FULL1     = 3;
    localparam int          BST_MEN       = 4;
    localparam int          ST_TABORT_SIG = 11;
    localparam int          ST_TABORT_RCV = 12;
    localparam int          ST_MABORT     = 13;
    localparam int          ST_PERR       = 15;
    localparam logic [15:0] STATUS_FIXED  = 16'h0280;
    localparam logic [15:0] STATUS_STICKY = 16'hb800;
    localparam logic [2:0]  CMD_RESET     = 3'h0;
    localparam logic [23:0] CLASS_CODE    = 24'h040000;
    localparam logic [7:0]  INT_PIN       = 8'h01;
    localparam logic [7:0]  MIN_GNT       = 8'hff;
    localparam logic [7:0]  MAX_LAT       = 8'h01;
    localparam logic [2:0]  MABORT_CLKS   = 3'h5;
endpackage

/* File: hdl/enc_host_bridge.sv */
// Purpose: Host bus target and bus master bridge of the video encoder.
// Assumes: Bus pins are synchronous to REF_CLK; FIFO_DATA and REG_RDATA are
//          valid the cycle after FIFO_RD or REG_RD.
// Notes:   Two-way pins are split into _IN, _OUT and _OE.
// Functional notes
// - Status bits 6 and 8 read zero
// - Status bit 7 reads one
// - Status bits 10:9 read 01b
// - Bit 11 set on issued target-abort
// - Bit 12 set on received target-abort
// - Bit 13 set on master-abort
// - Status bit 14 reads zero
// - Bit 15 set on parity error in a target write data phase
// - Status writes clear bits written one
// - Config claimed only with IDSEL, AD[1:0]=00
// - Config dword from AD[7:2], command from C/BE
// - Core reached via index then data port
// - Ports at 0, 4h, 8h; index persists
// - DEVSEL two clocks after address phase
// - Transfer on IRDY and TRDY; release after
// - Read turnaround after address; turnaround on release
// - Window one read pops one FIFO word per data phase
// - Window two read reads index 67h
// - Window two single data phase only
// - REQ when enabled and FIFO ready; start rules
// - Master write address, IRDY next, FRAME early
// - Threshold bursts, address steps four times threshold
// - Full sets flag, clears ready, interrupts
module enc_host_bridge #(
    parameter logic [31:0] ID_WORD  = 32'h5a5a_a5a5, // Arbitrary value
    parameter logic [7:0]  REV_CODE = 8'h01          // Arbitrary value
) (
    input  wire logic        REF_CLK,     // Bus clock
    input  wire logic        RST_B,       // Async reset, low active
    input  wire logic [31:0] AD_IN,       // Address/data sensed
    output logic      [31:0] AD_OUT,      // Address/data driven
    output logic             AD_OE,       // Address/data enable
    input  wire logic [3:0]  CBE_B_IN,    // Command/byte enables sensed
    output logic      [3:0]  CBE_B_OUT,   // Command/byte enables driven
    output logic             CBE_OE,      // Command/byte enable drive
    input  wire logic        PAR_IN,      // Parity sensed
    output logic             PAR_OUT,     // Parity driven
    output logic             PAR_OE,      // Parity enable
    input  wire logic        FRAME_B_IN,  // Frame sensed
    output logic             FRAME_B_OUT, // Frame driven
    output logic             FRAME_B_OE,  // Frame enable
    input  wire logic        IRDY_B_IN,   // Initiator ready sensed
    output logic             IRDY_B_OUT,  // Initiator ready driven
    output logic             IRDY_B_OE,   // Initiator ready enable
    input  wire logic        TRDY_B_IN,   // Target ready sensed
    output logic             TRDY_B_OUT,  // Target ready driven
    output logic             TRDY_B_OE,   // Target ready enable
    input  wire logic        DEVSEL_B_IN, // Device select sensed
    output logic             DEVSEL_B_OUT,// Device select driven
    output logic             DEVSEL_B_OE, // Device select enable
    input  wire logic        STOP_B_IN,   // Stop sensed
    output logic             STOP_B_OUT,  // Stop driven
    output logic             STOP_B_OE,   // Stop enable
    input  wire logic        IDSEL,       // Config select
    output logic             REQ_B,       // Bus request
    input  wire logic        GNT_B,       // Bus grant
    output logic             INT_B_OUT,   // Interrupt level, open drain
    output logic             INT_B_OE,    // Interrupt pull-down enable
    output logic      [6:0]  REG_ADDR,    // Core register index
    output logic      [31:0] REG_WDATA,   // Core write data
    output logic             REG_WR,      // Core write strobe
    output logic             REG_RD,      // Core read strobe
    input  wire logic [31:0] REG_RDATA,   // Core read data
    output logic             FIFO_RD,     // Output FIFO pop strobe
    input  wire logic [31:0] FIFO_DATA,   // Output FIFO word
    input  wire logic        FIFO_RDY,    // FIFO holds a threshold
    input  wire logic [15:0] THRESHOLD    // Threshold in words
);
    import enc_bridge_pkg::*;

    typedef enum logic [5:0] {
        T_IDLE = 6'b000001, T_DEC = 6'b000010, T_LOAD = 6'b000100,
        T_DATA = 6'b001000, T_HOLD = 6'b010000, T_TURN = 6'b100000
    } tgt_state_e;
    typedef enum logic [4:0] {
        M_IDLE = 5'b00001, M_ADDR = 5'b00010, M_LOAD = 5'b00100,
        M_DATA = 5'b01000, M_TURN = 5'b10000
    } mst_state_e;

    tgt_state_e  t_q;
    mst_state_e  m_q;
    logic        frame_prev_q, t_cfg_q, t_io_q, t_w1_q, t_w2_q, t_rd_q, t_abort_q;
    logic [7:0]  t_ofs_q, int_line_q;
    logic [31:0] t_data_q, m_word_q, m_off_q, wdata_q;
    logic [31:0] base_q [2];
    logic [31:0] size_q [2];
    logic [27:0] bar0_q;
    logic [19:0] bar1_q, bar2_q;
    logic [2:0]  cmd_q, dcnt_q;
    logic [15:0] stat_q, left_q;
    logic [6:0]  index_q;
    logic [4:0]  bst_q;
    logic        buf_sel_q, pend_q, m_pop_q, reg_wr_q, chk_q, chk_par_q, par_q;
    logic        par_oe_q, int_q, devsel_seen_q;

    logic cfg_hit, io_hit, w1_hit, w2_hit, claim, t_xfer, t_wr_xfer, m_xfer;
    logic m_want, m_start, m_pop, t_pop, idx_local, last_word, m_end, m_abort;
    logic [15:0] status_word, words_room;
    logic [31:0] cfg_rd, local_rd, rd_mux;

    // Address phase decode; own master cycles are never claimed
    assign cfg_hit = IDSEL && AD_IN[1:0] == 2'b00 &&
                     (CBE_B_IN == CMD_CFG_RD || CBE_B_IN == CMD_CFG_WR);
    assign io_hit  = cmd_q[0] && AD_IN[31:4] == bar0_q &&
                     (CBE_B_IN == CMD_IO_RD || CBE_B_IN == CMD_IO_WR);
    assign w1_hit  = cmd_q[1] && AD_IN[31:12] == bar1_q &&
                     (CBE_B_IN == CMD_MEM_RD || CBE_B_IN == CMD_MEM_RDM ||
                      CBE_B_IN == CMD_MEM_RDL);
    assign w2_hit  = cmd_q[1] && AD_IN[31:12] == bar2_q && CBE_B_IN == CMD_MEM_RD;
    assign claim   = frame_prev_q && !FRAME_B_IN && t_q == T_IDLE && m_q == M_IDLE &&
                     (cfg_hit || io_hit || w1_hit || w2_hit);
    assign t_xfer    = t_q == T_DATA && !t_abort_q && !IRDY_B_IN;
    assign t_wr_xfer = t_xfer && !t_rd_q;
    assign idx_local = index_q >= IDX_BUF0_BASE && index_q <= IDX_BUF_STATE;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            frame_prev_q <= 1'b1;
        end else begin
            frame_prev_q <= FRAME_B_IN;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            t_q <= T_IDLE;
            {t_cfg_q, t_io_q, t_w1_q, t_w2_q, t_rd_q, t_abort_q} <= 6'h00;
            t_ofs_q <= 8'h00;
        end else begin
            case (t_q)
                T_IDLE: if (claim) begin
                    t_q       <= T_DEC;
                    t_cfg_q   <= cfg_hit;
                    t_io_q    <= io_hit && !cfg_hit;
                    t_w1_q    <= w1_hit && !cfg_hit;
                    t_w2_q    <= w2_hit && !w1_hit && !cfg_hit;
                    t_rd_q    <= !CBE_B_IN[0];
                    t_ofs_q   <= AD_IN[7:0];
                    // Unused fourth port and writes to the stream port abort
                    t_abort_q <= io_hit && !cfg_hit && (AD_IN[3:0] > IO_STREAM_OFS ||
                                 (AD_IN[3:0] == IO_STREAM_OFS && CBE_B_IN[0]));
                end
                T_DEC:  t_q <= T_LOAD;
                T_LOAD: t_q <= T_DATA;
                T_DATA: begin
                    if (t_abort_q) begin
                        t_q <= FRAME_B_IN ? T_TURN : T_HOLD;
                    end else if (t_xfer) begin
                        if (!FRAME_B_IN && t_w1_q) begin
                            t_q <= T_LOAD;
                        end else begin
                            t_q <= FRAME_B_IN ? T_TURN : T_HOLD;
                        end
                    end
                end
                T_HOLD: if (FRAME_B_IN) begin
                    t_q <= T_TURN;
                end
                T_TURN: t_q <= T_IDLE;
                default: t_q <= T_IDLE;
            endcase
        end
    end

    // Target pins; TURN drives high one clock before release
    assign DEVSEL_B_OUT = !((t_q == T_LOAD || t_q == T_DATA || t_q == T_HOLD) &&
                            !t_abort_q);
    assign TRDY_B_OUT   = !(t_q == T_DATA && !t_abort_q);
    assign STOP_B_OUT   = !((t_q == T_DATA && (t_abort_q || !t_w1_q)) || t_q == T_HOLD);
    assign DEVSEL_B_OE  = t_q == T_LOAD || t_q == T_DATA || t_q == T_HOLD || t_q == T_TURN;
    assign TRDY_B_OE    = DEVSEL_B_OE;
    assign STOP_B_OE    = DEVSEL_B_OE;

    // Core side strobes
    assign t_pop   = (t_q == T_DEC && t_rd_q && !t_abort_q &&
                      (t_w1_q || (t_io_q && t_ofs_q[3:0] == IO_STREAM_OFS))) ||
                     (t_xfer && t_w1_q && !FRAME_B_IN);
    assign FIFO_RD = t_pop || m_pop;
    assign REG_RD  = t_q == T_DEC && t_rd_q && !t_abort_q && (t_w2_q ||
                     (t_io_q && t_ofs_q[3:0] == IO_DATA_OFS && !idx_local));
    assign REG_ADDR  = t_w2_q ? IDX_SOUND : index_q;
    assign REG_WR    = reg_wr_q;
    assign REG_WDATA = wdata_q;

    always_comb begin
        case (t_ofs_q[7:2])
            CFG_ID:      cfg_rd = ID_WORD;
            CFG_CMDSTAT: cfg_rd = {status_word, 13'h0000, cmd_q};
            CFG_CLASS:   cfg_rd = {CLASS_CODE, REV_CODE};
            CFG_BAR0:    cfg_rd = {bar0_q, 4'h1};
            CFG_BAR1:    cfg_rd = {bar1_q, 12'h000};
            CFG_BAR2:    cfg_rd = {bar2_q, 12'h000};
            CFG_INTR:    cfg_rd = {MAX_LAT, MIN_GNT, INT_PIN, int_line_q};
            default:     cfg_rd = 32'h0000_0000;
        endcase
        case (index_q)
            IDX_BUF0_BASE: local_rd = base_q[0];
            IDX_BUF1_BASE: local_rd = base_q[1];
            IDX_BUF0_SIZE: local_rd = size_q[0];
            IDX_BUF1_SIZE: local_rd = size_q[1];
            IDX_BUF_STATE: local_rd = {27'h0000000, bst_q};
            default:       local_rd = 32'h0000_0000;
        endcase
        if (t_cfg_q) begin
            rd_mux = cfg_rd;
        end else if (t_w1_q || (t_io_q && t_ofs_q[3:0] == IO_STREAM_OFS)) begin
            rd_mux = FIFO_DATA;
        end else if (t_w2_q) begin
            rd_mux = REG_RDATA;
        end else if (t_ofs_q[3:0] == IO_INDEX_OFS) begin
            rd_mux = {25'h0000000, index_q};
        end else begin
            rd_mux = idx_local ? local_rd : REG_RDATA;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            t_data_q <= 32'h0000_0000;
        end else if (t_q == T_LOAD) begin
            t_data_q <= rd_mux;
        end
    end

    // Config and index port writes
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cmd_q      <= CMD_RESET;
            bar0_q     <= 28'h0000000;
            bar1_q     <= 20'h00000;
            bar2_q     <= 20'h00000;
            int_line_q <= 8'h00;
            index_q    <= 7'h00;
            reg_wr_q   <= 1'b0;
            wdata_q    <= 32'h0000_0000;
        end else begin
            reg_wr_q <= t_wr_xfer && t_io_q && t_ofs_q[3:0] == IO_DATA_OFS && !idx_local;
            if (t_wr_xfer && t_io_q) begin
                wdata_q <= AD_IN;
            end
            if (t_wr_xfer && t_io_q && t_ofs_q[3:0] == IO_INDEX_OFS) begin
                index_q <= AD_IN[6:0];
            end
            if (t_wr_xfer && t_cfg_q) begin
                case (t_ofs_q[7:2])
                    CFG_CMDSTAT: if (!CBE_B_IN[0]) begin
                        cmd_q <= AD_IN[2:0];
                    end
                    CFG_BAR0: bar0_q <= AD_IN[31:4];
                    CFG_BAR1: bar1_q <= AD_IN[31:12];
                    CFG_BAR2: bar2_q <= AD_IN[31:12];
                    CFG_INTR: if (!CBE_B_IN[0]) begin
                        int_line_q <= AD_IN[7:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Status: sticky events, write one to clear, setting beats clearing
    assign status_word = (stat_q & STATUS_STICKY) | STATUS_FIXED;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat_q    <= 16'h0000;
            chk_q     <= 1'b0;
            chk_par_q <= 1'b0;
        end else begin
            chk_q     <= t_wr_xfer;
            chk_par_q <= ^{AD_IN, CBE_B_IN};
            if (t_wr_xfer && t_cfg_q && t_ofs_q[7:2] == CFG_CMDSTAT) begin
                stat_q <= stat_q & ~{CBE_B_IN[3] ? 8'h00 : AD_IN[31:24],
                                     CBE_B_IN[2] ? 8'h00 : AD_IN[23:16]};
            end
            if (t_q == T_DATA && t_abort_q) begin
                stat_q[ST_TABORT_SIG] <= 1'b1;
            end
            if (m_abort && devsel_seen_q) begin
                stat_q[ST_TABORT_RCV] <= 1'b1;
            end
            if (m_abort && !devsel_seen_q) begin
                stat_q[ST_MABORT] <= 1'b1;
            end
            if (chk_q && PAR_IN != chk_par_q) begin
                stat_q[ST_PERR] <= 1'b1;
            end
        end
    end

    // Master side
    assign m_want = bst_q[BST_MEN] && cmd_q[2] && FIFO_RDY && t_q == T_IDLE &&
                    bst_q[buf_sel_q ? BST_RDY1 : BST_RDY0];
    assign REQ_B   = !(m_want && m_q == M_IDLE);
    assign m_start = m_q == M_IDLE && m_want && !GNT_B && FRAME_B_IN && IRDY_B_IN;
    assign m_xfer  = m_q == M_DATA && !IRDY_B_OUT && !TRDY_B_IN;
    assign m_abort = m_q == M_DATA && !STOP_B_IN && DEVSEL_B_IN ||
                     m_q == M_DATA && DEVSEL_B_IN && !devsel_seen_q && dcnt_q >= MABORT_CLKS;
    assign last_word = left_q == 16'h0001;
    assign m_end   = m_xfer && (last_word || !STOP_B_IN);
    assign m_pop   = (m_start && !pend_q) || (m_xfer && !m_end);
    assign words_room = 16'((size_q[buf_sel_q] - m_off_q) >> 2);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            m_q           <= M_IDLE;
            left_q        <= 16'h0000;
            dcnt_q        <= 3'h0;
            devsel_seen_q <= 1'b0;
        end else begin
            case (m_q)
                M_IDLE: if (m_start) begin
                    m_q    <= M_ADDR;
                    left_q <= THRESHOLD < words_room ? THRESHOLD : words_room;
                end
                M_ADDR: m_q <= M_DATA;
                M_LOAD: m_q <= M_DATA;
                M_DATA: begin
                    if (m_abort || m_end) begin
                        m_q <= M_TURN;
                    end else if (m_xfer) begin
                        m_q <= M_LOAD;
                    end
                    if (m_xfer) begin
                        left_q <= left_q - 16'h0001;
                    end
                end
                M_TURN: m_q <= M_IDLE;
                default: m_q <= M_IDLE;
            endcase
            dcnt_q        <= m_q == M_ADDR ? 3'h1 : (dcnt_q < MABORT_CLKS ? dcnt_q + 3'h1 : dcnt_q);
            devsel_seen_q <= m_q == M_ADDR ? 1'b0 : (devsel_seen_q || !DEVSEL_B_IN);
        end
    end

    // Buffer bookkeeping and the local registers
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            base_q[0] <= 32'h0000_0000;
            base_q[1] <= 32'h0000_0000;
            size_q[0] <= 32'h0000_0000;
            size_q[1] <= 32'h0000_0000;
            bst_q     <= 5'h00;
            buf_sel_q <= 1'b0;
            m_off_q   <= 32'h0000_0000;
            pend_q    <= 1'b0;
            m_pop_q   <= 1'b0;
            m_word_q  <= 32'h0000_0000;
            int_q     <= 1'b0;
        end else begin
            m_pop_q <= m_pop;
            int_q   <= bst_q[BST_FULL0] || bst_q[BST_FULL1];
            if (m_pop_q) begin
                m_word_q <= FIFO_DATA;
            end
            pend_q <= m_pop || (pend_q && !m_xfer);
            if (t_wr_xfer && t_io_q && t_ofs_q[3:0] == IO_DATA_OFS) begin
                case (index_q)
                    IDX_BUF0_BASE: base_q[0] <= AD_IN;
                    IDX_BUF1_BASE: base_q[1] <= AD_IN;
                    IDX_BUF0_SIZE: size_q[0] <= AD_IN;
                    IDX_BUF1_SIZE: size_q[1] <= AD_IN;
                    IDX_BUF_STATE: begin
                        bst_q[BST_RDY1:BST_RDY0] <= AD_IN[BST_RDY1:BST_RDY0];
                        bst_q[BST_FULL1:BST_FULL0] <= bst_q[BST_FULL1:BST_FULL0] &
                                                      ~AD_IN[BST_FULL1:BST_FULL0];
                        bst_q[BST_MEN] <= AD_IN[BST_MEN];
                    end
                    default: ;
                endcase
            end
            if (!bst_q[BST_MEN]) begin
                buf_sel_q <= 1'b0;
                m_off_q   <= 32'h0000_0000;
            end else if (m_xfer) begin
                if (m_off_q + 32'h4 >= size_q[buf_sel_q]) begin
                    bst_q[buf_sel_q ? BST_FULL1 : BST_FULL0] <= 1'b1;
                    bst_q[buf_sel_q ? BST_RDY1 : BST_RDY0]   <= 1'b0;
                    buf_sel_q <= !buf_sel_q;
                    m_off_q   <= 32'h0000_0000;
                end else begin
                    m_off_q <= m_off_q + 32'h4;
                end
            end
        end
    end

    // Shared pins
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            par_q    <= 1'b0;
            par_oe_q <= 1'b0;
        end else begin
            par_q    <= ^{AD_OUT, CBE_B_OUT};
            par_oe_q <= AD_OE;
        end
    end
    assign AD_OUT = m_q == M_ADDR ? base_q[buf_sel_q] + m_off_q :
                    (m_q == M_IDLE ? t_data_q : m_word_q);
    // Read data waits one clock after the address for turnaround
    assign AD_OE  = (t_rd_q && (t_q == T_LOAD || t_q == T_DATA)) ||
                    m_q == M_ADDR || m_q == M_LOAD || m_q == M_DATA;
    assign CBE_B_OUT   = m_q == M_ADDR ? CMD_MEM_WR : 4'h0;
    assign CBE_OE      = m_q == M_ADDR || m_q == M_LOAD || m_q == M_DATA;
    assign FRAME_B_OUT = !(m_q == M_ADDR || m_q == M_LOAD ||
                           (m_q == M_DATA && !last_word && !m_abort));
    assign IRDY_B_OUT  = m_q != M_DATA;
    assign FRAME_B_OE  = CBE_OE || m_q == M_TURN;
    assign IRDY_B_OE   = FRAME_B_OE;
    assign PAR_OUT     = par_q;
    assign PAR_OE      = par_oe_q;
    assign INT_B_OUT   = 1'b0;
    assign INT_B_OE    = int_q;
endmodule

/* File: test/bridge_chk.sv */
// Purpose: Bus timing checks on the bridge pins
// Assumes: Bound to enc_host_bridge
// Notes:   Target and master phases
module bridge_chk (
    input wire logic       REF_CLK, RST_B, FRAME_B_IN, IRDY_B_IN, GNT_B, REQ_B, FIFO_RDY, AD_OE,
    input wire logic       FRAME_B_OUT, FRAME_B_OE, IRDY_B_OUT, IRDY_B_OE, TRDY_B_OUT,
    input wire logic       TRDY_B_OE, DEVSEL_B_OUT, DEVSEL_B_OE,
    input wire logic [3:0] CBE_B_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    a_dev_delay: assert property ($rose(DEVSEL_B_OE & !DEVSEL_B_OUT) |->
        $past(FRAME_B_IN, 3) & !$past(FRAME_B_IN, 2)) else $error("select late");
    a_trdy_dev: assert property ($rose(TRDY_B_OE & !TRDY_B_OUT) |->
        $past(DEVSEL_B_OE & !DEVSEL_B_OUT)) else $error("ready before select");
    a_read_turn: assert property ($rose(AD_OE) & !FRAME_B_OE |->
        $past(FRAME_B_IN, 3) & !$past(FRAME_B_IN, 2)) else $error("no turnaround");
    a_xfer_rel: assert property (TRDY_B_OE & !TRDY_B_OUT & !IRDY_B_IN & FRAME_B_IN |=>
        TRDY_B_OUT & DEVSEL_B_OUT ##1 !TRDY_B_OE) else $error("no release");
    a_req_fifo: assert property (!REQ_B |-> FIFO_RDY) else $error("request idle");
    a_start_gnt: assert property ($rose(FRAME_B_OE) |->
        $past(!GNT_B & FRAME_B_IN & IRDY_B_IN) & REQ_B & CBE_B_OUT == 4'h7) else $error("start");
    a_irdy_next: assert property ($rose(FRAME_B_OE) |=>
        IRDY_B_OE & !IRDY_B_OUT & CBE_B_OUT == 4'h0) else $error("data phase");
    a_frame_last: assert property ($rose(FRAME_B_OUT) & FRAME_B_OE |->
        !IRDY_B_OUT) else $error("frame end");
endmodule
bind enc_host_bridge bridge_chk u_chk (.*);

/* File: test/host_mem.sv */
// Purpose: Arbiter and memory target seen by the bridge master
// Assumes: Fast select, no wait states
// Notes:   Records first and last burst address and word count
module host_mem (
    input  wire logic        clk, rst_b, fo, fb, ib, rq,
    input  wire logic [31:0] ad,
    output logic             gnt_b, dev_b, trdy_b,
    output logic      [31:0] first_addr, last_addr,
    output int               words
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {gnt_b, dev_b, trdy_b} <= 3'h7;
            {first_addr, last_addr, words} <= '0;
        end else begin
            gnt_b <= rq;
            if (fo && !fb && dev_b) begin
                {dev_b, trdy_b} <= 2'h0;
                last_addr <= ad;
                if (first_addr == 0) first_addr <= ad;
            end
            if (!ib && !trdy_b) words <= words + 1;
            if (!ib && !trdy_b && fb) {dev_b, trdy_b} <= 2'h3;
        end
    end
endmodule

/* File: test/tb.sv */
// Purpose: Host-side test of the encoder bus bridge
// Assumes: Released lines float high; idle host address lines invert
// Notes:   Threshold 2, buffer zero of 16 bytes
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import enc_bridge_pkg::*;
    logic REF_CLK = 0, RST_B = 0, IDSEL = 0, FIFO_RDY = 1, h_fr = 1, h_ir = 1, h_on = 0, pq = 0;
    logic [31:0] h_ad = 0, FIFO_DATA = 32'h100, rd, first_addr, last_addr, AD_OUT, REG_WDATA;
    logic [15:0] THRESHOLD = 16'h2;
    logic [6:0]  REG_ADDR;
    logic [3:0]  h_cb = 0, CBE_B_OUT;
    logic AD_OE, CBE_OE, PAR_OUT, PAR_OE, FRAME_B_OUT, FRAME_B_OE, IRDY_B_OUT, IRDY_B_OE, TRDY_B_OUT,
        TRDY_B_OE, DEVSEL_B_OUT, DEVSEL_B_OE, STOP_B_OUT, STOP_B_OE, REQ_B, INT_B_OUT, INT_B_OE,
        REG_WR, REG_RD, FIFO_RD, GNT_B, mt, md;
    int err_total = 0, samples_checked = 0, n, words;
    wire [31:0] AD_IN = AD_OE ? AD_OUT : h_on ? h_ad : ~h_ad;
    wire [31:0] REG_RDATA = {25'h0, REG_ADDR};
    wire [3:0] CBE_B_IN = CBE_OE ? CBE_B_OUT : h_cb;
    wire FRAME_B_IN = FRAME_B_OE ? FRAME_B_OUT : h_fr;
    wire IRDY_B_IN = IRDY_B_OE ? IRDY_B_OUT : h_ir;
    wire TRDY_B_IN = TRDY_B_OE ? TRDY_B_OUT : mt;
    wire DEVSEL_B_IN = DEVSEL_B_OE ? DEVSEL_B_OUT : md;
    wire STOP_B_IN = !STOP_B_OE | STOP_B_OUT;
    wire PAR_IN = PAR_OE ? PAR_OUT : pq;
    enc_host_bridge dut (.*);
    host_mem mem (.clk(REF_CLK), .rst_b(RST_B), .fo(FRAME_B_OE), .fb(FRAME_B_IN), .ib(IRDY_B_IN),
        .rq(REQ_B), .ad(AD_IN), .gnt_b(GNT_B), .dev_b(md), .trdy_b(mt),
        .first_addr(first_addr), .last_addr(last_addr), .words(words));
    always #5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        pq <= ^{AD_IN, CBE_B_IN};
        if (FIFO_RD) FIFO_DATA <= FIFO_DATA + 1;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Single data phase; odd commands are writes, so reads release AD
    task automatic bus(input logic [3:0] c, input logic [31:0] a, d, input logic sel);
        @(posedge REF_CLK);
        {h_fr, h_on, h_ad, h_cb, IDSEL} <= {1'b0, 1'b1, a, c, sel};
        @(posedge REF_CLK);
        {h_fr, h_ir, h_on, h_ad, h_cb, IDSEL} <= {2'b10, c[0], d, 5'h0};
        for (n = 0; n < 20 && TRDY_B_IN !== 1'b0 && STOP_B_IN !== 1'b0; n++) @(posedge REF_CLK);
        rd = AD_IN;
        if (n == 20) begin
            chk(0, 1);
            end_sim;
        end
        {h_ir, h_on} <= 2'b10;
    endtask
    task automatic io(input logic [6:0] i, input logic [31:0] d);
        bus(CMD_IO_WR, 32'h1000, {25'h0, i}, 1);
        bus(CMD_IO_WR, 32'h1004, d, 0);
    endtask
    initial begin
        repeat (12) @(posedge REF_CLK);
        RST_B <= 1;
        bus(CMD_CFG_WR, 32'h10, 32'h1000, 1);
        bus(CMD_CFG_WR, 32'h14, 32'h20000, 1);
        bus(CMD_CFG_WR, 32'h18, 32'h30000, 1);
        bus(CMD_CFG_WR, 32'h4, 32'hffff_0007, 1);
        bus(CMD_CFG_RD, 32'h4, 0, 1);
        chk(rd, {STATUS_FIXED, 16'h0007});
        // Writing the stream port is refused with a target-abort
        bus(CMD_IO_WR, 32'h1008, 0, 0);
        bus(CMD_CFG_RD, 32'h4, 0, 1);
        chk(rd, {STATUS_FIXED | 16'h0800, 16'h0007});
        bus(CMD_CFG_WR, 32'h4, 32'h0800_0007, 1);
        bus(CMD_CFG_RD, 32'h4, 0, 1);
        chk(rd, {STATUS_FIXED, 16'h0007});
        io(IDX_BUF0_BASE, 32'h4000);
        io(IDX_BUF0_SIZE, 32'h10);
        bus(CMD_IO_RD, 32'h1004, 0, 0);
        chk(rd, 32'h10);
        bus(CMD_MEM_RD, 32'h20ffc, 0, 0);
        chk(rd, 32'h101);
        bus(CMD_MEM_RD, 32'h20000, 0, 0);
        chk(rd, 32'h102);
        bus(CMD_MEM_RD, 32'h30008, 0, 0);
        chk(rd, {25'h0, IDX_SOUND});
        $display("target tests done");
        FIFO_RDY <= 0;
        io(IDX_BUF_STATE, 32'h11);
        repeat (3) @(posedge REF_CLK);
        chk(REQ_B, 1);
        FIFO_RDY <= 1;
        for (n = 0; n < 300 && INT_B_OE !== 1'b1; n++) @(posedge REF_CLK);
        chk(INT_B_OE, 1);
        chk(first_addr, 32'h4000);
        chk(last_addr, 32'h4008);
        chk(words, 4);
        bus(CMD_IO_RD, 32'h1004, 0, 0);
        chk(rd, 32'h14);
        chk(REQ_B, 1);
        $display("master test done");
        end_sim;
    end
endmodule
